/* File: src/ddr_sram_ctrl_defines.vh */
// Constants for the burst-of-two separate-port SRAM model
`ifndef DDR_SRAM_CTRL_DEFINES_VH
`define DDR_SRAM_CTRL_DEFINES_VH
`define MCLK_PERIOD_NS   50
`define MODE_WINDOW_NS   1000
`define BYTE_W           9
`define DATA_W           36
`define NUM_LANES        4
`define PIN_CTRL_W       10
`define DATA_RESET       36'h0_0000_0000
`define FIFO_DEPTH       32
`define FIFO_PTR_W       5
`define BURST_STEP       2'h1
`endif

/* File: src/wr_fifo.v */
// Write command FIFO with valid/ready on both sides
`timescale 1ns/10ps
module wr_fifo #(
   parameter W     = 8,
   parameter DEPTH = 32,
   parameter PW    = 5
) (
   input  wire          i_mclk,
   input  wire          i_resetn,
   input  wire [W-1:0]  i_in_data,
   input  wire          i_in_valid,
   output wire          o_in_ready,
   output reg  [W-1:0]  o_out_data,
   output wire          o_out_valid,
   input  wire          i_out_ready
);
   reg [W-1:0]  mem [0:DEPTH-1];
   reg [PW-1:0] wptr;
   reg [PW-1:0] rptr;
   reg [PW:0]   count;
   wire         push;
   wire         pop;

   assign o_in_ready  = (count != DEPTH[PW:0]);
   assign o_out_valid = (count != {(PW+1){1'b0}});
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always @* begin
      o_out_data = mem[rptr];
   end

   always @(posedge i_mclk) begin
      if (push) begin
         mem[wptr] <= i_in_data;
      end
   end

   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         wptr  <= {PW{1'b0}};
         rptr  <= {PW{1'b0}};
         count <= {(PW+1){1'b0}};
      end else begin
         if (push) begin
            wptr <= (wptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : wptr + 1'b1;
         end
         if (pop) begin
            rptr <= (rptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : rptr + 1'b1;
         end
         count <= count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end
endmodule

/* File: src/ddr_sram_ctrl.v */
// Burst-of-two separate read/write port SRAM, clocks sampled by i_mclk
`timescale 1ns/10ps
`include "ddr_sram_ctrl_defines.vh"
module ddr_sram_ctrl #(
   parameter AW     = 6,
   parameter NBYTES = `NUM_LANES
) (
   input  wire                 i_mclk,
   input  wire                 i_resetn,
   input  wire                 i_kclk,
   input  wire                 i_kclk_n,
   input  wire                 i_cclk,
   input  wire                 i_cclk_n,
   input  wire                 i_read_sel_n,
   input  wire                 i_write_sel_n,
   input  wire                 i_byte_enable0_n,
   input  wire                 i_byte_enable1_n,
   input  wire                 i_byte_enable2_n,
   input  wire                 i_byte_enable3_n,
   input  wire [AW-1:0]        i_addr,
   input  wire [`DATA_W-1:0]   i_data,
   output reg  [`DATA_W-1:0]   o_q,
   output reg                  o_q_oe,
   output reg                  o_single_clock,
   output wire                 o_write_ready
);
   // ***************************************************************
   // Constants and states
   // ***************************************************************
   localparam PW       = `PIN_CTRL_W + AW + `DATA_W;
   localparam MODE_CYC = (`MODE_WINDOW_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
   localparam [7:0] MODE_CYC_W = MODE_CYC[7:0];
   localparam FW       = AW + 2 * (`NUM_LANES + `DATA_W);
   localparam [1:0] RD_IDLE = 2'b01;
   localparam [1:0] RD_REG  = 2'b10;
   localparam [1:0] WR_IDLE = 2'b01;
   localparam [1:0] WR_HALF = 2'b10;

   // ***************************************************************
   // Pin synchronisers with agreement filter
   // ***************************************************************
   wire [PW-1:0] pins;
   reg  [PW-1:0] s1;
   reg  [PW-1:0] s2;
   reg  [PW-1:0] s3;
   reg  [PW-1:0] pf;
   reg  [3:0]    clk_d;

   assign pins = {i_cclk_n, i_cclk, i_kclk_n, i_kclk, i_read_sel_n, i_write_sel_n,
                  i_byte_enable3_n, i_byte_enable2_n, i_byte_enable1_n, i_byte_enable0_n,
                  i_addr, i_data};

   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         s1    <= {PW{1'b1}};
         s2    <= {PW{1'b1}};
         s3    <= {PW{1'b1}};
         pf    <= {PW{1'b1}};
         clk_d <= 4'hF;
      end else begin
         s1    <= pins;
         s2    <= s1;
         s3    <= s2;
         pf    <= (s3 & ~(s2 ^ s3)) | (pf & (s2 ^ s3));
         clk_d <= pf[PW-1:PW-4];
      end
   end

   wire [`DATA_W-1:0] p_data = pf[`DATA_W-1:0];
   wire [AW-1:0]      p_addr = pf[AW+`DATA_W-1:`DATA_W];
   wire [3:0]         p_be_n = pf[AW+`DATA_W+3:AW+`DATA_W];
   wire               p_w_n  = pf[PW-6];
   wire               p_r_n  = pf[PW-5];
   wire [3:0]         p_clk  = pf[PW-1:PW-4];
   wire               k_rise  = p_clk[0] & ~clk_d[0];
   wire               kn_rise = p_clk[1] & ~clk_d[1];
   wire               c_rise  = p_clk[2] & ~clk_d[2];
   wire               cn_rise = p_clk[3] & ~clk_d[3];

   // ***************************************************************
   // Single-clock mode capture after reset release
   // ***************************************************************
   reg [7:0] mode_cnt;

   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_cnt       <= 8'h00;
         o_single_clock <= 1'b1;
      end else if (mode_cnt != MODE_CYC_W) begin
         mode_cnt <= mode_cnt + 8'h01;
         if (!p_clk[2] || !p_clk[3]) begin
            o_single_clock <= 1'b0;
         end
      end
   end

   wire out_rise  = o_single_clock ? k_rise : c_rise;
   wire out_rise2 = o_single_clock ? kn_rise : cn_rise;

   // ***************************************************************
   // Byte masks
   // ***************************************************************
   reg  [3:0]         be0_n;
   wire [`DATA_W-1:0] mask_a;
   wire [`DATA_W-1:0] mask_b;
   wire [FW-1:0]      f_out;
   wire [3:0]         f_be1_n = f_out[2*`DATA_W+7:2*`DATA_W+4];
   wire [3:0]         f_be0_n = f_out[`DATA_W+3:`DATA_W];

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_LANES; gi = gi + 1) begin : g_lane
         // Each enable owns one nine-bit lane; unused lanes in narrow builds stay off
         assign mask_a[gi*`BYTE_W +: `BYTE_W] = {`BYTE_W{~f_be0_n[gi] & (gi < NBYTES)}};
         assign mask_b[gi*`BYTE_W +: `BYTE_W] = {`BYTE_W{~f_be1_n[gi] & (gi < NBYTES)}};
      end
   endgenerate

   // ***************************************************************
   // Write state machine
   // ***************************************************************
   reg [1:0]          wr_state;
   reg [`DATA_W-1:0]  wd0;
   reg                push;
   reg [FW-1:0]       push_word;
   wire               f_valid;
   wire               f_ready;
   wire               pop;

   assign o_write_ready = f_ready;

   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_state  <= WR_IDLE;
         wd0       <= `DATA_RESET;
         be0_n     <= 4'hF;
         push      <= 1'b0;
         push_word <= {FW{1'b0}};
      end else begin
         push <= 1'b0;
         case (wr_state)
            WR_IDLE: begin
               if (k_rise && !p_w_n && f_ready) begin
                  wd0      <= p_data;
                  be0_n    <= p_be_n;
                  wr_state <= WR_HALF;
               end
            end
            WR_HALF: begin
               if (kn_rise) begin
                  push      <= 1'b1;
                  push_word <= {p_addr, p_be_n, p_data, be0_n, wd0};
                  wr_state  <= WR_IDLE;
               end
            end
            default: wr_state <= WR_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Read state machine and output pipeline
   // ***************************************************************
   reg [1:0]    rd_state;
   reg [AW-1:0] rd_addr;
   reg          out_valid;
   reg [AW-1:0] out_addr;
   reg          second_due;

   wire          rd_pend  = (rd_state == RD_REG);
   wire          launch_v = k_rise ? rd_pend : out_valid;
   wire [AW-1:0] launch_a = k_rise ? rd_addr : out_addr;
   wire [AW-1:0] out_addr2 = {out_addr[AW-1:2], out_addr[1:0] + `BURST_STEP};

   reg [`DATA_W-1:0] mem [0:(1<<AW)-1];

   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_state   <= RD_IDLE;
         rd_addr    <= {AW{1'b0}};
         out_valid  <= 1'b0;
         out_addr   <= {AW{1'b0}};
         second_due <= 1'b0;
         o_q        <= `DATA_RESET;
         o_q_oe     <= 1'b0;
      end else begin
         if (k_rise) begin
            out_valid <= rd_pend;
            out_addr  <= rd_addr;
            case (rd_state)
               RD_IDLE,
               RD_REG: begin
                  rd_state <= p_r_n ? RD_IDLE : RD_REG;
                  rd_addr  <= p_addr;
               end
               default: rd_state <= RD_IDLE;
            endcase
         end
         if (out_rise) begin
            if (launch_v) begin
               o_q        <= mem[launch_a];
               o_q_oe     <= 1'b1;
               out_addr   <= launch_a;
               out_valid  <= 1'b0;
               second_due <= 1'b1;
            end else begin
               o_q_oe <= 1'b0;
            end
         end else if (out_rise2 && second_due) begin
            o_q        <= mem[out_addr2];
            second_due <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Write FIFO and array update
   // ***************************************************************
   wire [AW-1:0] f_addr0 = f_out[FW-1:FW-AW];
   wire [AW-1:0] f_addr1 = {f_addr0[AW-1:2], f_addr0[1:0] + `BURST_STEP};
   wire [`DATA_W-1:0] f_d0 = f_out[`DATA_W-1:0];
   wire [`DATA_W-1:0] f_d1 = f_out[2*`DATA_W+3:`DATA_W+4];

   // Array updates yield to read fetches so a fetch and an array update never fall in the same cycle
   assign pop = ~(out_rise | out_rise2);

   wr_fifo #(
      .W     (FW),
      .DEPTH (`FIFO_DEPTH),
      .PW    (`FIFO_PTR_W)
   ) u_wr_fifo (
      .i_mclk      (i_mclk),
      .i_resetn    (i_resetn),
      .i_in_data   (push_word),
      .i_in_valid  (push),
      .o_in_ready  (f_ready),
      .o_out_data  (f_out),
      .o_out_valid (f_valid),
      .i_out_ready (pop)
   );

   always @(posedge i_mclk) begin
      if (f_valid && pop) begin
         mem[f_addr0] <= (mem[f_addr0] & ~mask_a) | (f_d0 & mask_a);
         mem[f_addr1] <= (mem[f_addr1] & ~mask_b) | (f_d1 & mask_b);
      end
   end
   // With no clock edges the write FIFO still drains into the array, while read state and o_q hold
endmodule

/* File: dv/sram_ctrl_checker.sv */
// Port checker for the separate-port SRAM block
`timescale 1ns/10ps
module sram_ctrl_checker #(
   parameter AW = 6
) (
   input wire          i_mclk,
   input wire          i_resetn,
   input wire          i_kclk,
   input wire          i_kclk_n,
   input wire          i_cclk,
   input wire          i_cclk_n,
   input wire          i_read_sel_n,
   input wire          i_write_sel_n,
   input wire          i_byte_enable0_n,
   input wire          i_byte_enable1_n,
   input wire          i_byte_enable2_n,
   input wire          i_byte_enable3_n,
   input wire [AW-1:0] i_addr,
   input wire [35:0]   i_data,
   input wire [35:0]   o_q,
   input wire          o_q_oe,
   input wire          o_single_clock,
   input wire          o_write_ready
);
   // ****
   // Helper counters
   // ****
   wire [3:0] clk_now = {i_kclk, i_kclk_n, i_cclk, i_cclk_n};
   reg  [5:0] rd_age;
   reg  [5:0] still;
   reg  [5:0] edge_age;
   reg  [3:0] clk_d;
   reg        c_low;
   always @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_age   <= 6'h3f;
         still    <= 6'h00;
         edge_age <= 6'h3f;
         clk_d    <= 4'h0;
         c_low    <= 1'b0;
      end else begin
         rd_age   <= !i_read_sel_n ? 6'h00 : rd_age + {5'h00, rd_age != 6'h3f};
         still    <= (clk_now != clk_d) ? 6'h00 : still + {5'h00, still != 6'h3f};
         edge_age <= |(clk_now & ~clk_d) ? 6'h00 : edge_age + {5'h00, edge_age != 6'h3f};
         clk_d    <= clk_now;
         c_low    <= c_low | ~i_cclk | ~i_cclk_n;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   oe_idle_a: assert property (rd_age > 6'h28 |-> !o_q_oe) else $error("oe idle");
   oe_cause_a: assert property ($rose(o_q_oe) |-> rd_age < 6'h1e) else $error("oe cause");
   stop_hold_a: assert property (still > 6'h0c |-> $stable(o_q) && $stable(o_q_oe)) else $error("stop");
   q_timing_a: assert property (!$stable(o_q) |-> edge_age < 6'h08) else $error("q timing");
   oe_timing_a: assert property (!$stable(o_q_oe) |-> edge_age < 6'h08) else $error("oe timing");
   mode_sticky_a: assert property (!o_single_clock |=> !o_single_clock) else $error("mode");
   mode_single_a: assert property (!c_low |-> o_single_clock) else $error("single");
   ready_back_a: assert property (!o_write_ready |-> ##[1:40] o_write_ready) else $error("ready");
   cover property ($rose(o_q_oe));
   cover property (o_single_clock && $rose(o_q_oe));
   cover property (still == 6'h20);
endmodule
bind ddr_sram_ctrl sram_ctrl_checker #(.AW(AW)) i_sram_ctrl_checker (
   .i_mclk           (i_mclk),
   .i_resetn         (i_resetn),
   .i_kclk           (i_kclk),
   .i_kclk_n         (i_kclk_n),
   .i_cclk           (i_cclk),
   .i_cclk_n         (i_cclk_n),
   .i_read_sel_n     (i_read_sel_n),
   .i_write_sel_n    (i_write_sel_n),
   .i_byte_enable0_n (i_byte_enable0_n),
   .i_byte_enable1_n (i_byte_enable1_n),
   .i_byte_enable2_n (i_byte_enable2_n),
   .i_byte_enable3_n (i_byte_enable3_n),
   .i_addr           (i_addr),
   .i_data           (i_data),
   .o_q              (o_q),
   .o_q_oe           (o_q_oe),
   .o_single_clock   (o_single_clock),
   .o_write_ready    (o_write_ready)
);

/* File: dv/ctrl_clk_model.sv */
// Controller-side model of the input and output clock pairs
`timescale 1ns/10ps
module ctrl_clk_model (
   input  wire i_run,
   input  wire i_single,
   output reg  o_kclk,
   output wire o_kclk_n,
   output wire o_cclk,
   output wire o_cclk_n
);
   // ****
   // Clock pairs, stopped while not running
   // ****
   initial begin
      o_kclk = 1'b0;
      #13;
      forever begin
         #200;
         if (i_run) o_kclk = ~o_kclk;
      end
   end
   // Output pair lags the input pair by a quarter period, so C and K timing differ
   wire k_late;
   assign #100 k_late = o_kclk;
   assign o_kclk_n = ~o_kclk;
   assign o_cclk   = i_single | k_late;
   assign o_cclk_n = i_single | ~k_late;
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the separate-port SRAM block
`timescale 1ns/10ps
module tb_top;
   reg         mclk, resetn, run, single, r_n, w_n;
   reg  [3:0]  be;
   reg  [5:0]  addr;
   reg  [35:0] data, held;
   reg  [35:0] mem_exp [0:63];
   wire [35:0] q;
   wire        k, k_n, c, c_n, oe, sc, wr;
   integer     bad_count, checks, cyc, i;
   // ****
   // Model, design and clock
   // ****
   ctrl_clk_model i_ctrl_clk_model (.i_run(run), .i_single(single), .o_kclk(k), .o_kclk_n(k_n), .o_cclk(c),
      .o_cclk_n(c_n));
   ddr_sram_ctrl #(.AW(6), .NBYTES(4)) i_ddr_sram_ctrl (.i_mclk(mclk), .i_resetn(resetn), .i_kclk(k),
      .i_kclk_n(k_n), .i_cclk(c), .i_cclk_n(c_n), .i_read_sel_n(r_n), .i_write_sel_n(w_n),
      .i_byte_enable0_n(be[0]), .i_byte_enable1_n(be[1]), .i_byte_enable2_n(be[2]), .i_byte_enable3_n(be[3]),
      .i_addr(addr), .i_data(data), .o_q(q), .o_q_oe(oe), .o_single_clock(sc), .o_write_ready(wr));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   task close_out;
      begin
         if (bad_count == 0 && checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [35:0] seen, input [35:0] want, input string what);
      begin
         checks = checks + 1;
         if (seen !== want) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
         end
      end
   endtask
   function [5:0] nxt(input [5:0] a);
      nxt = {a[5:2], a[1:0] + 2'h1};
   endfunction
   task merge(input [5:0] a, input [35:0] d, input [3:0] b);
      integer n;
      for (n = 0; n < 4; n = n + 1) if (!b[n]) mem_exp[a][9*n +: 9] = d[9*n +: 9];
   endtask
   task at_edge(input bit neg);
      begin
         if (neg) @(posedge k_n);
         else @(posedge k);
         repeat (2) @(posedge mclk);
      end
   endtask
   // ****
   // Scenarios
   // ****
   task write(input [5:0] a, input [35:0] d0, input [35:0] d1, input [3:0] b0, input [3:0] b1);
      begin
         @(negedge mclk);
         chk({35'h0, wr}, 36'h1, "write_ready");
         at_edge(1);
         w_n <= 1'b0;
         data <= d0;
         be <= b0;
         at_edge(0);
         addr <= a;
         data <= d1;
         be <= b1;
         at_edge(1);
         w_n <= 1'b1;
         data <= ~d1;
         be <= ~b1;
         merge(a, d0, b0);
         merge(nxt(a), d1, b1);
      end
   endtask
   task rd_check(input [5:0] a);
      begin
         @(posedge k);
         repeat (8) @(negedge mclk);
         chk(q, mem_exp[a], "word0");
         chk({35'h0, oe}, 36'h1, "oe_on");
         repeat (3) @(negedge mclk);
         chk(q, mem_exp[nxt(a)], "word1");
         chk({35'h0, oe}, 36'h1, "oe_word1");
         repeat (7) @(negedge mclk);
         chk({35'h0, oe}, 36'h0, "oe_off");
      end
   endtask
   task rd(input [5:0] a);
      begin
         at_edge(1);
         r_n <= 1'b0;
         addr <= a;
         at_edge(0);
         r_n <= 1'b1;
         addr <= ~a;
         rd_check(a);
      end
   endtask
   task both(input [5:0] ra, input [5:0] wa, input [35:0] d0, input [35:0] d1);
      begin
         at_edge(1);
         r_n <= 1'b0;
         w_n <= 1'b0;
         addr <= ra;
         data <= d0;
         be <= 4'h0;
         at_edge(0);
         r_n <= 1'b1;
         addr <= wa;
         data <= d1;
         at_edge(1);
         w_n <= 1'b1;
         data <= ~d1;
         rd_check(ra);
         merge(wa, d0, 4'h0);
         merge(nxt(wa), d1, 4'h0);
         rd(wa);
      end
   endtask
   task stop_test;
      begin
         held = q;
         @(posedge mclk) run <= 1'b0;
         repeat (30) @(negedge mclk);
         chk(q, held, "stop_q");
         chk({35'h0, oe}, 36'h0, "stop_oe");
         @(posedge mclk) run <= 1'b1;
         rd(6'h06);
      end
   endtask
   task reset_to(input bit sgl);
      begin
         @(posedge mclk) resetn <= 1'b0;
         run <= 1'b0;
         single <= sgl;
         repeat (2) @(posedge mclk);
         resetn <= 1'b1;
         repeat (25) @(negedge mclk);
         chk({35'h0, sc}, {35'h0, sgl}, "mode");
         @(posedge mclk) run <= 1'b1;
      end
   endtask
   initial begin
      {resetn, run, bad_count, checks, cyc} = 0;
      {single, r_n, w_n, be, addr, data} = {3'h7, 4'hf, 6'h00, 36'h0_0000_0000};
      reset_to(1);
      write(6'h04, 36'h1_2345_6789, 36'hE_DCBA_9876, 4'h0, 4'h0);
      rd(6'h04);
      reset_to(0);
      for (i = 0; i < 12; i = i + 2) write(i[5:0], 36'h0_1357_9BDF + i, 36'hF_0246_8ACE - i, 4'h0, 4'h0);
      write(6'h07, 36'hA_AAAA_AAAA, 36'h5_5555_5555, 4'h0, 4'hf);
      write(6'h09, 36'h3_C3C3_C3C3, 36'hC_3C3C_3C3C, 4'he, 4'h3);
      write(6'h02, 36'h9_6969_6969, 36'h6_9696_9696, 4'hd, 4'h7);
      rd(6'h07);
      rd(6'h09);
      rd(6'h02);
      both(6'h00, 6'h0a, 36'h7_7777_0000, 36'h0_0000_8888);
      stop_test;
      close_out;
   end
endmodule
